//--- core/imp_pkg.sv
// shared constants and carriers for the idle-mode and pin-configuration block
// assumes a classic wishbone master with 16-bit byte addresses and 32-bit data
package imp_pkg;
    // ==========================================================
    // register indices; the byte address on the bus is index*4
    localparam logic [15:0] IMP_IDX_INT_MASK_ONE = 16'h0013;
    localparam logic [15:0] IMP_IDX_P1_FSEL      = 16'h1f99;
    localparam logic [15:0] IMP_IDX_PORT1_DIRECTION       = 16'h1f9b;
    localparam logic [15:0] IMP_IDX_P1_DATA      = 16'h1f9d;
    localparam logic [15:0] IMP_IDX_P2_FSEL      = 16'h1fd0;
    localparam logic [15:0] IMP_IDX_P7_FSEL      = 16'h1fd1;
    localparam logic [15:0] IMP_IDX_PORT2_DIRECTION       = 16'h1fd2;
    localparam logic [15:0] IMP_IDX_PORT7_DIRECTION       = 16'h1fd3;
    localparam logic [15:0] IMP_IDX_P2_DATA      = 16'h1fd4;
    localparam logic [15:0] IMP_IDX_P7_DATA      = 16'h1fd5;
    localparam logic [15:0] IMP_IDX_P5_FSEL      = 16'h1ff1;
    localparam logic [15:0] IMP_IDX_PORT5_DIRECTION       = 16'h1ff3;
    localparam logic [15:0] IMP_IDX_P5_DATA      = 16'h1ff5;
    localparam logic [15:0] IMP_IDX_CHIP_CFG0    = 16'h2018;
    localparam logic [15:0] IMP_IDX_MODE_STATUS  = 16'h2019;
    localparam int          IMP_ADDR_W           = 16;

    // ==========================================================
    // field positions
    localparam int IMP_PD_EN_BIT   = 0;
    localparam int IMP_EXTERNAL_INTERRUPT_PIN_BIT  = 6;
    localparam int IMP_NPORTS      = 4;

    // ==========================================================
    // reset values
    localparam logic [7:0] IMP_RST_MASK  = 8'h00;
    localparam logic [7:0] IMP_RST_FSEL  = 8'h00;
    localparam logic [7:0] IMP_RST_DIR   = 8'hff;
    localparam logic [7:0] IMP_RST_DATA  = 8'hff;
    localparam logic [7:0] IMP_RST_CFG0  = 8'h00;

    // ==========================================================
    // instruction operands and watchdog
    localparam logic [7:0]  IMP_OP_IDLE      = 8'h01;
    localparam logic [7:0]  IMP_OP_POWERDOWN = 8'h02;
    localparam int          IMP_WDT_W        = 16;
    localparam logic [15:0] IMP_WDT_TOP      = 16'hffff;

    typedef enum logic [1:0]
    {
        IMP_ST_RUN  = 2'b00,
        IMP_ST_IDLE = 2'b01,
        IMP_ST_PD   = 2'b10
    } imp_state_t;

    // one port's pin drive: level, enable
    typedef struct packed
    {
        logic [7:0] level;
        logic [7:0] oe;
    } imp_pin_drive_t;
endpackage

//--- core/imp_top.sv
// idle/powerdown mode control and port pin configuration registers
// assumes a wishbone classic master on the same clock; pins are sampled through two flops
//
// Implementation choice: the Wishbone interface to the registers.
`timescale 1ns/100ps
`default_nettype none
module imp_top
(
    input  wire logic                       clk_i,
    input  wire logic                       rst_i,
    input  wire logic [imp_pkg::IMP_ADDR_W-1:0] wb_adr_i,
    input  wire logic [31:0]                wb_dat_i,
    input  wire logic [3:0]                 wb_sel_i,
    input  wire logic                       wb_we_i,
    input  wire logic                       wb_cyc_i,
    input  wire logic                       wb_stb_i,
    output logic [31:0]                     wb_dat_o,
    output logic                            wb_ack_o,
    input  wire logic [7:0]                 cfg_byte0_i,
    input  wire logic                       mode_cmd_i,
    input  wire logic [7:0]                 mode_operand_i,
    input  wire logic [7:0]                 irq_pending_i,
    input  wire logic                       wdt_enable_i,
    input  wire logic                       wdt_clear_i,
    input  wire logic [31:0]                periph_level_i,
    input  wire logic [31:0]                periph_oe_i,
    input  wire logic [31:0]                pin_i,
    output logic [31:0]                     pin_o,
    output logic [31:0]                     pin_oe_o,
    output logic [31:0]                     pin_sync_o,
    output logic                            cpu_clk_en_o,
    output logic                            periph_clk_en_o,
    output logic                            clock_output_pin_o,
    output logic                            wake_irq_o,
    output logic                            wdt_reset_o
);
    import imp_pkg::*;

    // ==========================================================
    // register storage
    logic [7:0]  interrupt_mask_one;
    logic [7:0]  chip_configuration_zero;
    logic [7:0]  fsel [IMP_NPORTS];
    logic [7:0]  dir  [IMP_NPORTS];
    logic [7:0]  dat  [IMP_NPORTS];
    logic        cfg_loaded;
    imp_state_t  state;
    logic [IMP_WDT_W-1:0] wdt_cnt;
    logic [31:0] pin_meta;
    logic [31:0] pin_sync;

    logic        bus_req;
    logic        bus_wr;
    logic [15:0] idx;
    logic [7:0]  wbyte;
    logic [7:0]  rbyte;
    logic        hit;
    logic        enabled_irq;

    assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign bus_wr  = bus_req && wb_we_i && wb_sel_i[0];
    assign idx     = {2'b00, wb_adr_i[15:2]};
    assign wbyte   = wb_dat_i[7:0];
    assign enabled_irq = |(irq_pending_i & interrupt_mask_one);

    // ==========================================================
    // port index decode: entry 0..3 = ports 1,2,5,7
    function automatic logic [2:0] port_of(input logic [15:0] a);
        logic [2:0] p;
        p = 3'b111;
        case (a)
            IMP_IDX_P1_FSEL, IMP_IDX_PORT1_DIRECTION, IMP_IDX_P1_DATA: p = 3'd0;
            IMP_IDX_P2_FSEL, IMP_IDX_PORT2_DIRECTION, IMP_IDX_P2_DATA: p = 3'd1;
            IMP_IDX_P5_FSEL, IMP_IDX_PORT5_DIRECTION, IMP_IDX_P5_DATA: p = 3'd2;
            IMP_IDX_P7_FSEL, IMP_IDX_PORT7_DIRECTION, IMP_IDX_P7_DATA: p = 3'd3;
            default: p = 3'b111;
        endcase
        return p;
    endfunction

    logic [2:0] port_sel;
    logic       is_fsel;
    logic       is_dir;
    logic       is_dat;
    assign port_sel = port_of(idx);
    assign is_fsel = (idx == IMP_IDX_P1_FSEL) || (idx == IMP_IDX_P2_FSEL)
                  || (idx == IMP_IDX_P5_FSEL) || (idx == IMP_IDX_P7_FSEL);
    assign is_dir  = (idx == IMP_IDX_PORT1_DIRECTION) || (idx == IMP_IDX_PORT2_DIRECTION)
                  || (idx == IMP_IDX_PORT5_DIRECTION) || (idx == IMP_IDX_PORT7_DIRECTION);
    assign is_dat  = (idx == IMP_IDX_P1_DATA) || (idx == IMP_IDX_P2_DATA)
                  || (idx == IMP_IDX_P5_DATA) || (idx == IMP_IDX_P7_DATA);

    // ==========================================================
    // read mux; unmapped addresses read zero and still ack
    always_comb
    begin
        rbyte = 8'h00;
        hit   = 1'b1;
        if (idx == IMP_IDX_INT_MASK_ONE)
            rbyte = interrupt_mask_one;
        else if (idx == IMP_IDX_CHIP_CFG0)
            rbyte = chip_configuration_zero;
        else if (idx == IMP_IDX_MODE_STATUS)
            rbyte = {6'h00, state};
        else if (port_sel != 3'b111)
        begin
            if (is_fsel)
                rbyte = fsel[port_sel[1:0]];
            else if (is_dir)
                rbyte = dir[port_sel[1:0]];
            else
                rbyte = dat[port_sel[1:0]];
        end
        else
            hit = 1'b0;
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end
        else
        begin
            wb_ack_o <= bus_req;
            wb_dat_o <= (bus_req && !wb_we_i && hit) ? {24'h000000, rbyte} : 32'h0000_0000;
        end
    end

    // ==========================================================
    // chip configuration: loaded once from the config byte after reset, never written by code
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            chip_configuration_zero <= IMP_RST_CFG0;
            cfg_loaded              <= 1'b0;
        end
        else if (!cfg_loaded)
        begin
            chip_configuration_zero <= cfg_byte0_i;
            cfg_loaded              <= 1'b1;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            interrupt_mask_one <= IMP_RST_MASK;
        else if (bus_wr && idx == IMP_IDX_INT_MASK_ONE)
            interrupt_mask_one <= wbyte;
    end

    // ==========================================================
    // per-port registers and pin drive; registers keep writing in idle as well
    genvar g;
    generate
        for (g = 0; g < IMP_NPORTS; g++)
        begin : g_port
            imp_pin_drive_t drv;
            always_ff @(posedge clk_i)
            begin
                if (rst_i)
                begin
                    fsel[g] <= IMP_RST_FSEL;
                    dir[g]  <= IMP_RST_DIR;
                    dat[g]  <= IMP_RST_DATA;
                end
                else if (bus_wr && port_sel == 3'(g))
                begin
                    if (is_fsel)
                        fsel[g] <= wbyte;
                    if (is_dir)
                        dir[g] <= wbyte;
                    if (is_dat)
                        dat[g] <= wbyte;  // stored even while peripheral owns the pin
                end
            end
            always_comb
            begin
                for (int b = 0; b < 8; b++)
                begin
                    // function select picks the source
                    drv.level[b] = fsel[g][b] ? periph_level_i[g*8+b] : dat[g][b];
                    // open drain when direction set: drive only a low
                    if (fsel[g][b])
                        drv.oe[b] = periph_oe_i[g*8+b] && (!dir[g][b] || !periph_level_i[g*8+b]);
                    else
                        drv.oe[b] = !dir[g][b] || !dat[g][b];
                end
            end
            always_ff @(posedge clk_i)
            begin
                if (rst_i)
                begin
                    pin_o[g*8 +: 8]    <= 8'hff;
                    pin_oe_o[g*8 +: 8] <= 8'h00;
                end
                else
                begin
                    pin_o[g*8 +: 8]    <= drv.level;
                    pin_oe_o[g*8 +: 8] <= drv.oe;
                end
            end
        end
    endgenerate

    // pin inputs through two flops before anything reads them; a third flop feeds the output
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            pin_meta   <= 32'h0000_0000;
            pin_sync   <= 32'h0000_0000;
            pin_sync_o <= 32'h0000_0000;
        end
        else
        begin
            pin_meta   <= pin_i;
            pin_sync   <= pin_meta;
            pin_sync_o <= pin_sync;
        end
    end

    // ==========================================================
    // operating mode; an enabled irq ends idle, only the external interrupt pin bit ends powerdown
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            state <= IMP_ST_RUN;  // hardware reset ends idle and returns to run
        else
        begin
            case (state)
                IMP_ST_RUN:
                begin
                    if (mode_cmd_i && mode_operand_i == IMP_OP_IDLE)
                        state <= IMP_ST_IDLE;
                    else if (mode_cmd_i && mode_operand_i == IMP_OP_POWERDOWN
                             && chip_configuration_zero[IMP_PD_EN_BIT])
                        state <= IMP_ST_PD;
                end
                IMP_ST_IDLE:
                begin
                    if (enabled_irq)
                        state <= IMP_ST_RUN;
                end
                IMP_ST_PD:
                begin
                    if (irq_pending_i[IMP_EXTERNAL_INTERRUPT_PIN_BIT])
                        state <= IMP_ST_RUN;
                end
                default: state <= IMP_ST_RUN;
            endcase
        end
    end

    // wake pulse tells the cpu to vector first, then resume after the idle instruction
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            wake_irq_o <= 1'b0;
        else
            wake_irq_o <= (state == IMP_ST_IDLE) && enabled_irq;
    end

    // clock enables: cpu stops in idle and powerdown, peripherals only in powerdown
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            cpu_clk_en_o       <= 1'b1;
            periph_clk_en_o    <= 1'b1;
            clock_output_pin_o <= 1'b0;
        end
        else
        begin
            cpu_clk_en_o       <= (state == IMP_ST_RUN);
            periph_clk_en_o    <= (state != IMP_ST_PD);
            clock_output_pin_o <= (state == IMP_ST_PD) ? 1'b1 : !clock_output_pin_o;
        end
    end

    // ==========================================================
    // watchdog keeps counting in idle; clock is stopped in powerdown
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            wdt_cnt     <= '0;
            wdt_reset_o <= 1'b0;
        end
        else
        begin
            wdt_reset_o <= 1'b0;
            if (!wdt_enable_i || wdt_clear_i)
                wdt_cnt <= '0;
            else if (state != IMP_ST_PD)
            begin
                if (wdt_cnt == IMP_WDT_TOP)
                begin
                    wdt_cnt     <= '0;
                    wdt_reset_o <= 1'b1;
                end
                else
                    wdt_cnt <= wdt_cnt + 1'b1;
            end
        end
    end

    // ==========================================================
    // checks
    property p_idle_entry;
        @(posedge clk_i) disable iff (rst_i)
        (state == IMP_ST_RUN && mode_cmd_i && mode_operand_i == IMP_OP_IDLE) |=> state == IMP_ST_IDLE;
    endproperty
    a_idle_entry: assert property (p_idle_entry) else $error("idle not entered");

    property p_pd_gate;
        @(posedge clk_i) disable iff (rst_i)
        (state == IMP_ST_RUN && $past(state) == IMP_ST_RUN) ##1 state == IMP_ST_PD
            |-> chip_configuration_zero[IMP_PD_EN_BIT];
    endproperty
    a_pd_gate: assert property (p_pd_gate) else $error("powerdown while disabled");

    property p_cpu_gated;
        @(posedge clk_i) disable iff (rst_i)
        state == IMP_ST_IDLE |=> !cpu_clk_en_o;
    endproperty
    a_cpu_gated: assert property (p_cpu_gated) else $error("cpu clock runs in idle");

    property p_periph_run;
        @(posedge clk_i) disable iff (rst_i)
        state == IMP_ST_IDLE |=> periph_clk_en_o;
    endproperty
    a_periph_run: assert property (p_periph_run) else $error("peripheral clock stopped in idle");

    property p_wake;
        @(posedge clk_i) disable iff (rst_i)
        (state == IMP_ST_IDLE && enabled_irq) |=> state == IMP_ST_RUN && wake_irq_o ##1 cpu_clk_en_o;
    endproperty
    a_wake: assert property (p_wake) else $error("no wake on enabled irq");

    property p_masked_stays;
        @(posedge clk_i) disable iff (rst_i)
        (state == IMP_ST_IDLE && !enabled_irq) |=> state == IMP_ST_IDLE;
    endproperty
    a_masked_stays: assert property (p_masked_stays) else $error("left idle without enabled irq");

    property p_port_drive;
        @(posedge clk_i) disable iff (rst_i)
        !fsel[0][4] && !dir[0][4] |=> pin_o[4] == $past(dat[0][4]) && pin_oe_o[4];
    endproperty
    a_port_drive: assert property (p_port_drive) else $error("port pin not following data");

    property p_periph_own;
        @(posedge clk_i) disable iff (rst_i)
        fsel[1][4] |=> pin_o[12] == $past(periph_level_i[12]);
    endproperty
    a_periph_own: assert property (p_periph_own) else $error("data reached peripheral pin");

    property p_open_drain;
        @(posedge clk_i) disable iff (rst_i)
        !fsel[2][0] && dir[2][0] && dat[2][0] |=> !pin_oe_o[16];
    endproperty
    a_open_drain: assert property (p_open_drain) else $error("open drain drove high");

    c_idle_wake: cover property (@(posedge clk_i) disable iff (rst_i)
        state == IMP_ST_IDLE ##[1:50] wake_irq_o);
    c_pd: cover property (@(posedge clk_i) disable iff (rst_i) state == IMP_ST_PD);
    c_wdt: cover property (@(posedge clk_i) disable iff (rst_i) wdt_reset_o);
endmodule
`default_nettype wire

//--- verif/tb_imp_top.sv
// self-checking bench for the idle-mode and pin-configuration block
// assumes imp_pkg is compiled first; drives wishbone, mode, irq and pin inputs directly
`timescale 1ns/100ps
`default_nettype none
module tb_imp_top;
    import imp_pkg::*;
    // ==========================================================
    // stimulus and observed signals
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic [15:0] wb_adr_i = 16'h0;
    logic [31:0] wb_dat_i = 32'h0;
    logic [3:0]  wb_sel_i = 4'h0;
    logic        wb_we_i = 1'b0;
    logic        wb_cyc_i = 1'b0;
    logic        wb_stb_i = 1'b0;
    logic [7:0]  cfg_byte0_i = 8'h00;
    logic        mode_cmd_i = 1'b0;
    logic [7:0]  mode_operand_i = 8'h00;
    logic [7:0]  irq_pending_i = 8'h00;
    logic        wdt_enable_i = 1'b0;
    logic        wdt_clear_i = 1'b0;
    logic [31:0] periph_level_i = 32'h5a5a5a5a;
    logic [31:0] periph_oe_i = 32'hc3c3c3c3;
    logic [31:0] pin_i = 32'h0;
    logic [31:0] wb_dat_o;
    logic        wb_ack_o;
    logic [31:0] pin_o;
    logic [31:0] pin_oe_o;
    logic [31:0] pin_sync_o;
    logic        cpu_clk_en_o;
    logic        periph_clk_en_o;
    logic        clock_output_pin_o;
    logic        wake_irq_o;
    logic        wdt_reset_o;
    int          num_errors = 0;
    int          compares = 0;
    logic [31:0] rd;
    logic        c1;
    int          n;
    // port order 1, 2, 5, 7 matches the pin slices
    localparam logic [15:0] FSEL [4] = '{IMP_IDX_P1_FSEL, IMP_IDX_P2_FSEL, IMP_IDX_P5_FSEL, IMP_IDX_P7_FSEL};
    localparam logic [15:0] DIR  [4] = '{IMP_IDX_PORT1_DIRECTION, IMP_IDX_PORT2_DIRECTION, IMP_IDX_PORT5_DIRECTION, IMP_IDX_PORT7_DIRECTION};
    localparam logic [15:0] DAT  [4] = '{IMP_IDX_P1_DATA, IMP_IDX_P2_DATA, IMP_IDX_P5_DATA, IMP_IDX_P7_DATA};

    always #4 clk_i = ~clk_i;

    imp_top u_dut
    (
        .clk_i              (clk_i),
        .rst_i              (rst_i),
        .wb_adr_i           (wb_adr_i),
        .wb_dat_i           (wb_dat_i),
        .wb_sel_i           (wb_sel_i),
        .wb_we_i            (wb_we_i),
        .wb_cyc_i           (wb_cyc_i),
        .wb_stb_i           (wb_stb_i),
        .wb_dat_o           (wb_dat_o),
        .wb_ack_o           (wb_ack_o),
        .cfg_byte0_i        (cfg_byte0_i),
        .mode_cmd_i         (mode_cmd_i),
        .mode_operand_i     (mode_operand_i),
        .irq_pending_i      (irq_pending_i),
        .wdt_enable_i       (wdt_enable_i),
        .wdt_clear_i        (wdt_clear_i),
        .periph_level_i     (periph_level_i),
        .periph_oe_i        (periph_oe_i),
        .pin_i              (pin_i),
        .pin_o              (pin_o),
        .pin_oe_o           (pin_oe_o),
        .pin_sync_o         (pin_sync_o),
        .cpu_clk_en_o       (cpu_clk_en_o),
        .periph_clk_en_o    (periph_clk_en_o),
        .clock_output_pin_o (clock_output_pin_o),
        .wake_irq_o         (wake_irq_o),
        .wdt_reset_o        (wdt_reset_o)
    );

    // ==========================================================
    // report, compare and wait helpers
    task automatic end_of_test();
        $display("errors %0d compares %0d", num_errors, compares);
        if (num_errors == 0 && compares > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic tick(input int k);
        repeat (k) @(posedge clk_i);
    endtask

    // a wait that runs out is a mismatch and closes the run
    task automatic wait_high(ref logic s, input int lim, output int cnt);
        cnt = 0;
        do
        begin
            @(posedge clk_i);
            cnt++;
        end
        while (s !== 1'b1 && cnt < lim);
        if (s !== 1'b1)
        begin
            num_errors++;
            end_of_test();
        end
    endtask

    // ==========================================================
    // wishbone classic cycle: hold until ack is sampled, then release
    task automatic bus(input logic [15:0] idx, input logic we, input logic [7:0] wd, input logic [3:0] sel);
        @(posedge clk_i);
        wb_adr_i <= {idx[13:0], 2'b00};
        wb_we_i  <= we;
        wb_dat_i <= {24'h0, wd};
        wb_sel_i <= sel;
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wait_high(wb_ack_o, 16, n);
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i  <= 1'b0;
    endtask

    task automatic wr(input logic [15:0] idx, input logic [7:0] wd);
        bus(idx, 1'b1, wd, 4'h1);
    endtask

    task automatic rd_chk(input logic [15:0] idx, input logic [7:0] exp);
        bus(idx, 1'b0, 8'h00, 4'hf);
        check(rd, {24'h0, exp});
    endtask

    task automatic mode(input logic [7:0] op);
        @(posedge clk_i);
        mode_cmd_i     <= 1'b1;
        mode_operand_i <= op;
        @(posedge clk_i);
        mode_cmd_i     <= 1'b0;
        tick(3);
    endtask

    task automatic irq(input logic [7:0] v);
        @(posedge clk_i);
        irq_pending_i <= v;
    endtask

    task automatic do_reset(input logic [7:0] cfg);
        @(posedge clk_i);
        rst_i       <= 1'b1;
        cfg_byte0_i <= cfg;
        tick(5);
        rst_i <= 1'b0;
        tick(1);
        cfg_byte0_i <= 8'h00;
    endtask

    // expected pin drive worked out from function-select, direction and data
    task automatic pin_chk(input int p, input logic [7:0] fs, input logic [7:0] dr, input logic [7:0] da);
        logic [7:0] oe;
        logic [7:0] lv;
        oe = (fs & periph_oe_i[p*8+:8] & (~dr | ~periph_level_i[p*8+:8])) | (~fs & (~dr | ~da));
        lv = (fs & periph_level_i[p*8+:8]) | (~fs & ~dr & da);
        check({24'h0, pin_oe_o[p*8+:8]}, {24'h0, oe});
        check({24'h0, pin_o[p*8+:8] & oe}, {24'h0, lv & oe});
    endtask

    // ==========================================================
    // main sequence
    initial
    begin
        do_reset(8'h00);
        rd_chk(IMP_IDX_INT_MASK_ONE, IMP_RST_MASK);
        for (int p = 0; p < 4; p++)
        begin
            rd_chk(FSEL[p], IMP_RST_FSEL);
            rd_chk(DIR[p], IMP_RST_DIR);
            rd_chk(DAT[p], IMP_RST_DATA);
        end
        rd_chk(IMP_IDX_CHIP_CFG0, 8'h00);
        bus(IMP_IDX_INT_MASK_ONE, 1'b1, 8'hff, 4'he);
        rd_chk(IMP_IDX_INT_MASK_ONE, 8'h00);
        wr(16'h0100, 8'hff);
        bus(16'h0100, 1'b0, 8'h00, 4'hf);
        check(rd, 32'h0);
        wr(IMP_IDX_CHIP_CFG0, 8'hff);
        rd_chk(IMP_IDX_CHIP_CFG0, 8'h00);
        wr(IMP_IDX_INT_MASK_ONE, 8'h96);
        rd_chk(IMP_IDX_INT_MASK_ONE, 8'h96);
        // pins: port mode, open drain, peripheral hand-over, stored writes
        for (int p = 0; p < 4; p++)
        begin
            wr(FSEL[p], 8'h00);
            wr(DIR[p], 8'h0f);
            wr(DAT[p], 8'ha5);
            tick(2);
            pin_chk(p, 8'h00, 8'h0f, 8'ha5);
            wr(FSEL[p], 8'hf0);
            tick(2);
            pin_chk(p, 8'hf0, 8'h0f, 8'ha5);
            wr(DAT[p], 8'h3c);
            tick(2);
            pin_chk(p, 8'hf0, 8'h0f, 8'h3c);
            rd_chk(DAT[p], 8'h3c);
            rd_chk(FSEL[p], 8'hf0);
            rd_chk(DIR[p], 8'h0f);
            wr(FSEL[p], 8'h00);
            tick(2);
            pin_chk(p, 8'h00, 8'h0f, 8'h3c);
        end
        // port 1 input pins get a one in their data bit so nothing pulls them low
        wr(DAT[0], 8'h3f);
        tick(2);
        pin_chk(0, 8'h00, 8'h0f, 8'h3f);
        @(posedge clk_i);
        pin_i <= 32'h0f1e2d3c;
        tick(5);
        check(pin_sync_o, 32'h0f1e2d3c);
        // idle entry, masked external source, then wake
        wr(IMP_IDX_INT_MASK_ONE, 8'h00);
        mode(IMP_OP_IDLE);
        check({31'h0, cpu_clk_en_o}, 32'h0);
        check({31'h0, periph_clk_en_o}, 32'h1);
        rd_chk(IMP_IDX_MODE_STATUS, 8'h01);
        rd_chk(DAT[1], 8'h3c);
        c1 = clock_output_pin_o;
        tick(1);
        check({31'h0, clock_output_pin_o}, {31'h0, ~c1});
        irq(8'h40);
        tick(6);
        check({31'h0, cpu_clk_en_o}, 32'h0);
        wr(IMP_IDX_INT_MASK_ONE, 8'h40);
        wait_high(wake_irq_o, 12, n);
        tick(2);
        check({31'h0, cpu_clk_en_o}, 32'h1);
        rd_chk(IMP_IDX_MODE_STATUS, 8'h00);
        irq(8'h00);
        // internal source wakes as well
        wr(IMP_IDX_INT_MASK_ONE, 8'h04);
        mode(IMP_OP_IDLE);
        check({31'h0, cpu_clk_en_o}, 32'h0);
        irq(8'h04);
        wait_high(wake_irq_o, 12, n);
        tick(2);
        check({31'h0, cpu_clk_en_o}, 32'h1);
        irq(8'h00);
        // powerdown refused while the enable bit is clear
        mode(IMP_OP_POWERDOWN);
        check({31'h0, cpu_clk_en_o}, 32'h1);
        rd_chk(IMP_IDX_MODE_STATUS, 8'h00);
        // hardware reset in idle returns to run and loads the enable bit
        mode(IMP_OP_IDLE);
        check({31'h0, cpu_clk_en_o}, 32'h0);
        do_reset(8'h01);
        check({31'h0, cpu_clk_en_o}, 32'h1);
        rd_chk(IMP_IDX_CHIP_CFG0, 8'h01);
        rd_chk(IMP_IDX_MODE_STATUS, 8'h00);
        wr(IMP_IDX_INT_MASK_ONE, 8'h40);
        mode(IMP_OP_POWERDOWN);
        check({31'h0, cpu_clk_en_o}, 32'h0);
        check({31'h0, periph_clk_en_o}, 32'h0);
        tick(1);
        check({31'h0, clock_output_pin_o}, 32'h1);
        tick(1);
        check({31'h0, clock_output_pin_o}, 32'h1);
        irq(8'h40);
        wait_high(cpu_clk_en_o, 20, n);
        tick(1);
        check({31'h0, periph_clk_en_o}, 32'h1);
        irq(8'h00);
        // watchdog keeps counting in idle and pulses wdt_reset_o when it reaches the top
        @(posedge clk_i);
        wdt_enable_i <= 1'b1;
        wdt_clear_i  <= 1'b1;
        @(posedge clk_i);
        wdt_clear_i  <= 1'b0;
        mode(IMP_OP_IDLE);
        wait_high(wdt_reset_o, 70000, n);
        check({31'h0, (n > 65000 && n < 65600)}, 32'h1);
        end_of_test();
    end
endmodule
`default_nettype wire
